/* File: pkg/psrc_pkg.sv */
// Constants, register map and state type for the sleep and restart controller.
package psrc_pkg;
    localparam logic [7:0] MODE_ONE_ADDR = 8'h00;
    localparam logic [7:0] MODE_TWO_ADDR = 8'h01;
    localparam logic [7:0] PWM_FIRST_ADDR = 8'h06;
    localparam logic [7:0] PWM_LAST_ADDR = 8'h45;
    localparam logic [7:0] GLOBAL_FIRST_ADDR = 8'hF0;
    localparam logic [7:0] GLOBAL_LAST_ADDR = 8'hF3;
    localparam logic [6:0] GLOBAL_INDEX = 7'h40;
    localparam logic [7:0] MODE_ONE_RESET = 8'h11;
    localparam logic [7:0] MODE_TWO_RESET = 8'h04;
    localparam logic [7:0] MODE_TWO_WRITE_MASK = 8'h1F;
    localparam logic [7:0] PWM_HIGH_MASK = 8'h1F;
    localparam logic [7:0] OFF_HIGH_RESET = 8'h10;
    localparam int BIT_RESTART = 7;
    localparam int BIT_EXT_CLOCK = 6;
    localparam int BIT_AUTOSTEP = 5;
    localparam int BIT_SLEEP = 4;
    localparam int BIT_SUB_ONE = 3;
    localparam int BIT_SUB_TWO = 2;
    localparam int BIT_SUB_THREE = 1;
    localparam int BIT_BROADCAST = 0;
    localparam int BIT_OUTPUT_ON_ACK = 3;
    localparam int BIT_FULL_OFF = 4;
    localparam int CHANNELS = 16;
    localparam int PWM_BYTES = 4 * CHANNELS + 4;
    localparam logic [11:0] PWM_COUNT_LAST = 12'hFFF;
    localparam int CLK_MHZ = 200;
    localparam int STARTUP_TIME_US = 500;
    localparam int STARTUP_CYCLES_DEF = STARTUP_TIME_US * CLK_MHZ;
    localparam int OSC_DIV_DEF = 8;
    typedef enum logic [1:0] {PSRC_RUN, PSRC_DRAIN, PSRC_ASLEEP} psrc_state_e;
endpackage

/* File: rtl/psrc_sync3.sv */
// Three-stage synchroniser for the external clock pin with agreement filter.
`timescale 1ns/1ps
`default_nettype none
module psrc_sync3 (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic d,
    output logic q
);
    logic s1;
    logic s2;
    logic s3;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            q <= 1'b0;
        end else begin
            s1 <= d;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                q <= s3;
            end
        end
    end
endmodule
`default_nettype wire

/* File: rtl/psrc_osc.sv */
// Oscillator model: start-up wait for the internal source, ticks from either source.
`timescale 1ns/1ps
`default_nettype none
module psrc_osc #(
    parameter int STARTUP_CYCLES = 100000,
    parameter int OSC_DIV = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic ext_sel,
    input wire logic ext_level,
    output logic running,
    output logic tick
);
    localparam int WW = $clog2(STARTUP_CYCLES + 1);
    localparam int DW = $clog2(OSC_DIV);
    logic [WW-1:0] wait_cnt;
    logic [DW-1:0] div_cnt;
    logic ext_prev;
    logic [WW:0] wake_cnt;

    generate
        if (STARTUP_CYCLES < 1 || OSC_DIV < 2) begin : g_bad
            $error("psrc_osc: STARTUP_CYCLES must be >= 1 and OSC_DIV >= 2");
        end
    endgenerate

    wire logic wait_done = wait_cnt == WW'(STARTUP_CYCLES - 1);
    wire logic div_last = div_cnt == DW'(OSC_DIV - 1);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            running <= 1'b0;
            wait_cnt <= '0;
            div_cnt <= '0;
            ext_prev <= 1'b0;
        end else begin
            ext_prev <= ext_level;
            if (!enable) begin
                running <= 1'b0;
                wait_cnt <= '0;
            end else if (ext_sel) begin
                running <= 1'b1;
            end else if (wait_done) begin
                running <= 1'b1;
            end else if (!running) begin
                wait_cnt <= wait_cnt + WW'(1);
            end
            div_cnt <= (running && !div_last) ? div_cnt + DW'(1) : '0;
        end
    end

    // The external source ticks on each filtered rising edge, the internal one by division.
    assign tick = running && (ext_sel ? (ext_level && !ext_prev) : div_last);

    always_ff @(posedge clk) begin
        if (!rst_n || !enable || running) begin
            wake_cnt <= '0;
        end else begin
            wake_cnt <= wake_cnt + (WW + 1)'(1);
        end
    end

    a_startup_bound: assert property (@(posedge clk) disable iff (!rst_n)
        wake_cnt <= (WW + 1)'(STARTUP_CYCLES)) else $error("oscillator start-up too long");
    a_ext_no_delay: assert property (@(posedge clk) disable iff (!rst_n)
        enable && ext_sel && !running |=> running) else $error("external clock start delayed");
endmodule
`default_nettype wire

/* File: rtl/psrc_top.sv */
// Sleep, oscillator, restart and address-enable control of the LED PWM controller.
`timescale 1ns/1ps
`default_nettype none
module psrc_top import psrc_pkg::*; #(
    parameter int STARTUP_CYCLES = STARTUP_CYCLES_DEF,
    parameter int OSC_DIV = OSC_DIV_DEF
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sw_reset,
    input wire logic ptr_load,
    input wire logic [7:0] ptr_value,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    input wire logic bus_stop,
    input wire logic ext_clk_pin,
    output logic [7:0] reg_pointer,
    output logic [7:0] reg_rdata,
    output logic respond_sub_one,
    output logic respond_sub_two,
    output logic respond_sub_three,
    output logic respond_broadcast,
    output logic oscillator_running,
    output logic pwm_running,
    output logic [11:0] pwm_count,
    output logic pwm_period_end,
    output logic [CHANNELS-1:0] channel_active,
    output logic channel_restart,
    output logic [8*PWM_BYTES-1:0] pwm_regs
);
    logic [7:0] mode_one;
    logic [7:0] mode_two;
    logic [7:0] pwm_mem [0:PWM_BYTES-1];
    logic [3:0] wr_seen [0:CHANNELS];
    logic pwm_dirty;
    psrc_state_e state;
    psrc_state_e next_state;
    logic osc_tick;
    logic ext_level;

    generate
        if (STARTUP_CYCLES < 1 || OSC_DIV < 2) begin : g_bad
            $error("psrc_top: STARTUP_CYCLES must be >= 1 and OSC_DIV >= 2");
        end
    endgenerate

    // A general-call software reset returns everything to its power-on state.
    wire logic srst_n = rst_n && !sw_reset;

    wire logic hit_mode_one = reg_pointer == MODE_ONE_ADDR;
    wire logic hit_mode_two = reg_pointer == MODE_TWO_ADDR;
    wire logic hit_pwm = reg_pointer >= PWM_FIRST_ADDR && reg_pointer <= PWM_LAST_ADDR;
    wire logic hit_global = reg_pointer >= GLOBAL_FIRST_ADDR && reg_pointer <= GLOBAL_LAST_ADDR;
    wire logic [7:0] pwm_off = reg_pointer - PWM_FIRST_ADDR;
    wire logic [7:0] glb_off = reg_pointer - GLOBAL_FIRST_ADDR;
    wire logic [6:0] mem_index = hit_pwm ? pwm_off[6:0] : GLOBAL_INDEX + {5'h00, glb_off[1:0]};
    wire logic [4:0] slot = mem_index[6:2];
    wire logic [1:0] byte_sel = mem_index[1:0];
    wire logic [3:0] byte_bit = 4'h1 << byte_sel;
    wire logic pwm_write = reg_wr && (hit_pwm || hit_global);
    wire logic [7:0] pwm_wdata = mem_index[0] ? (reg_wdata & PWM_HIGH_MASK) : reg_wdata;
    wire logic slot_complete = pwm_write && ((wr_seen[slot] | byte_bit) == 4'hF);
    wire logic mode_one_write = reg_wr && hit_mode_one;

    wire logic sleep = mode_one[BIT_SLEEP];
    wire logic update_on_ack = mode_two[BIT_OUTPUT_ON_ACK];
    wire logic any_active = |channel_active;
    wire logic awake = state != PSRC_ASLEEP;
    wire logic count_step = osc_tick && awake;
    assign pwm_period_end = count_step && pwm_count == PWM_COUNT_LAST;

    // The flag is raised only once the running period has been finished.
    wire logic restart_set = state == PSRC_DRAIN && pwm_period_end;
    wire logic restart_write = mode_one_write && reg_wdata[BIT_RESTART];
    wire logic stop_clear = !update_on_ack && bus_stop && (pwm_dirty || pwm_write);
    wire logic ack_clear = update_on_ack && slot_complete;
    wire logic orderly_clear = state == PSRC_RUN && sleep && !any_active;
    wire logic restart_clear = restart_write || stop_clear || ack_clear || orderly_clear;
    // Set beats clear so a period ending during a clearing write is not lost.
    wire logic next_restart = restart_set || (mode_one[BIT_RESTART] && !restart_clear);
    // The source switch only takes while the sleep bit is already set, and it cannot be undone by a write.
    wire logic next_ext_clock = mode_one[BIT_EXT_CLOCK] ||
        (mode_one_write && reg_wdata[BIT_EXT_CLOCK] && sleep && reg_wdata[BIT_SLEEP]);
    wire logic [5:0] next_low = mode_one_write ? reg_wdata[5:0] : mode_one[5:0];
    wire logic [7:0] next_mode_one = {next_restart, next_ext_clock, next_low};

    wire logic [7:0] next_rdata = hit_mode_one ? mode_one :
                                  hit_mode_two ? mode_two :
                                  hit_pwm ? pwm_mem[mem_index] : 8'h00;

    assign respond_sub_one = mode_one[BIT_SUB_ONE];
    assign respond_sub_two = mode_one[BIT_SUB_TWO];
    assign respond_sub_three = mode_one[BIT_SUB_THREE];
    assign respond_broadcast = mode_one[BIT_BROADCAST];
    assign pwm_running = oscillator_running && awake;

    genvar gi;
    generate
        for (gi = 0; gi < CHANNELS; gi++) begin : g_active
            assign channel_active[gi] = !pwm_mem[4 * gi + 3][BIT_FULL_OFF] &&
                                        !pwm_mem[GLOBAL_INDEX + 3][BIT_FULL_OFF];
        end
        for (gi = 0; gi < PWM_BYTES; gi++) begin : g_flat
            assign pwm_regs[8 * gi +: 8] = pwm_mem[gi];
        end
    endgenerate

    always_comb begin
        next_state = state;
        unique case (state)
            PSRC_RUN: begin
                if (sleep) begin
                    next_state = (any_active && oscillator_running) ? PSRC_DRAIN : PSRC_ASLEEP;
                end
            end
            PSRC_DRAIN: begin
                if (pwm_period_end) begin
                    next_state = PSRC_ASLEEP;
                end
            end
            PSRC_ASLEEP: begin
                if (!sleep) begin
                    next_state = PSRC_RUN;
                end
            end
            default: next_state = PSRC_ASLEEP;
        endcase
    end

    psrc_sync3 u_ext_sync (
        .clk(clk),
        .rst_n(srst_n),
        .d(ext_clk_pin),
        .q(ext_level)
    );

    psrc_osc #(
        .STARTUP_CYCLES(STARTUP_CYCLES),
        .OSC_DIV(OSC_DIV)
    ) u_osc (
        .clk(clk),
        .rst_n(srst_n),
        .enable(awake),
        .ext_sel(mode_one[BIT_EXT_CLOCK]),
        .ext_level(ext_level),
        .running(oscillator_running),
        .tick(osc_tick)
    );

    always_ff @(posedge clk) begin
        if (!srst_n) begin
            state <= PSRC_ASLEEP;
            mode_one <= MODE_ONE_RESET;
            mode_two <= MODE_TWO_RESET;
            pwm_count <= 12'h000;
            reg_rdata <= 8'h00;
            channel_restart <= 1'b0;
        end else begin
            state <= next_state;
            mode_one <= next_mode_one;
            if (reg_wr && hit_mode_two) begin
                mode_two <= reg_wdata & MODE_TWO_WRITE_MASK;
            end
            if (count_step) begin
                pwm_count <= pwm_count + 12'h001;
            end
            if (reg_rd) begin
                reg_rdata <= next_rdata;
            end
            channel_restart <= restart_write && mode_one[BIT_RESTART];
        end
    end

    always_ff @(posedge clk) begin
        if (!srst_n) begin
            reg_pointer <= 8'h00;
        end else if (ptr_load) begin
            reg_pointer <= ptr_value;
        end else if ((reg_wr || reg_rd) && mode_one[BIT_AUTOSTEP]) begin
            reg_pointer <= reg_pointer + 8'h01;
        end
    end

    // Contents survive sleep untouched; only writes and resets change them.
    always_ff @(posedge clk) begin
        if (!srst_n) begin
            for (int i = 0; i < PWM_BYTES; i++) begin
                pwm_mem[i] <= ((i % 4) == 3) ? OFF_HIGH_RESET : 8'h00;
            end
            for (int k = 0; k <= CHANNELS; k++) begin
                wr_seen[k] <= 4'h0;
            end
            pwm_dirty <= 1'b0;
        end else begin
            if (pwm_write) begin
                pwm_mem[mem_index] <= pwm_wdata;
                wr_seen[slot] <= slot_complete ? 4'h0 : (wr_seen[slot] | byte_bit);
            end
            pwm_dirty <= bus_stop ? 1'b0 : (pwm_dirty || pwm_write);
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!srst_n);

    a_sleep_stops_osc: assert property (
        state == PSRC_ASLEEP |=> !oscillator_running) else $error("oscillator runs while asleep");
    a_sub_enable_follow: assert property (
        mode_one_write |=> respond_sub_one == $past(reg_wdata[BIT_SUB_ONE]) &&
        respond_sub_two == $past(reg_wdata[BIT_SUB_TWO]) &&
        respond_sub_three == $past(reg_wdata[BIT_SUB_THREE])) else $error("subaddress enable wrong");
    a_broadcast_follow: assert property (
        mode_one_write |=> respond_broadcast == $past(reg_wdata[BIT_BROADCAST]))
        else $error("broadcast enable wrong");
    a_pointer_step: assert property (
        (reg_wr || reg_rd) && !ptr_load && mode_one[BIT_AUTOSTEP] |=> reg_pointer == $past(reg_pointer) + 8'h01)
        else $error("pointer did not advance");
    a_pointer_hold: assert property (
        (reg_wr || reg_rd) && !ptr_load && !mode_one[BIT_AUTOSTEP] |=> $stable(reg_pointer))
        else $error("pointer moved without autostep");
    a_count_frozen: assert property (
        !pwm_running |=> $stable(pwm_count)) else $error("PWM counter moved while stopped");
    a_drain_sets_flag: assert property (
        restart_set |=> mode_one[BIT_RESTART] && state == PSRC_ASLEEP) else $error("restart flag not set");
    a_regs_held: assert property (
        state == PSRC_ASLEEP && !pwm_write |=> $stable(pwm_regs)) else $error("PWM registers changed asleep");
    a_restart_clears: assert property (
        restart_write && mode_one[BIT_RESTART] && !restart_set |=> !mode_one[BIT_RESTART] && channel_restart)
        else $error("restart write did not clear and resume");
    a_sw_reset_clears: assert property (@(posedge clk) disable iff (!rst_n)
        sw_reset |=> !mode_one[BIT_RESTART] && mode_one == MODE_ONE_RESET) else $error("software reset ignored");
    a_stop_clears: assert property (
        stop_clear && !restart_set |=> !mode_one[BIT_RESTART]) else $error("stop did not clear flag");
    a_ack_clears: assert property (
        ack_clear && !restart_set |=> !mode_one[BIT_RESTART]) else $error("channel load did not clear flag");
    a_orderly_clear: assert property (
        orderly_clear |=> !mode_one[BIT_RESTART] && state == PSRC_ASLEEP) else $error("orderly shutdown kept flag");
    a_zero_write_keeps: assert property (
        mode_one_write && !reg_wdata[BIT_RESTART] && mode_one[BIT_RESTART] && !stop_clear && !ack_clear &&
        !orderly_clear |=> mode_one[BIT_RESTART]) else $error("zero write changed restart flag");

    c_drain_to_sleep: cover property (state == PSRC_DRAIN && restart_set);
    c_restart_fire: cover property (channel_restart);
    c_ack_complete: cover property (ack_clear);
    c_wake_run: cover property (state == PSRC_RUN && $rose(pwm_running));
endmodule
`default_nettype wire

/* File: verification/psrc_host_model.sv */
// Behavioural model of the bus controller that programs the sleep and restart controller.
`timescale 1ns/1ps
`default_nettype none
module psrc_host_model import psrc_pkg::*; #(
    parameter int STARTUP_CYCLES = 20
) (
    input wire logic clk,
    output logic ptr_load,
    output logic [7:0] ptr_value,
    output logic reg_wr,
    output logic [7:0] reg_wdata,
    output logic reg_rd,
    output logic bus_stop,
    input wire logic [7:0] reg_rdata
);
    initial begin
        ptr_load = 1'b0;
        ptr_value = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
        bus_stop = 1'b0;
    end

    // Released data lines show the inverse of the last value, so stale data never passes for fresh.
    task automatic put(input logic [7:0] addr, input logic [7:0] data, input bit load);
        @(negedge clk);
        if (load) begin
            ptr_load = 1'b1;
            ptr_value = addr;
            @(negedge clk);
            ptr_load = 1'b0;
            ptr_value = ~addr;
        end
        reg_wr = 1'b1;
        reg_wdata = data;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_wdata = ~data;
    endtask

    task automatic get(input logic [7:0] addr, output logic [7:0] data);
        @(negedge clk);
        ptr_load = 1'b1;
        ptr_value = addr;
        @(negedge clk);
        ptr_load = 1'b0;
        ptr_value = ~addr;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        @(negedge clk);
        data = reg_rdata;
    endtask

    task automatic stop();
        @(negedge clk);
        bus_stop = 1'b1;
        @(negedge clk);
        bus_stop = 1'b0;
    endtask

    // The PWM registers are left alone until the oscillator has surely settled.
    task automatic wake(input logic [7:0] mode);
        put(MODE_ONE_ADDR, mode, 1'b1);
        repeat (STARTUP_CYCLES + 8) @(negedge clk);
    endtask

    task automatic resume_outputs();
        logic [7:0] m;
        get(MODE_ONE_ADDR, m);
        if (m[BIT_RESTART]) begin
            wake(8'h21);
            put(MODE_ONE_ADDR, 8'hA1, 1'b1);
        end
    endtask

    task automatic quiesce();
        put(8'hF3, 8'h10, 1'b1);
    endtask
endmodule
`default_nettype wire

/* File: verification/test_pwm_sleep_restart_control.sv */
// Self-checking testbench for the sleep, oscillator and restart controller.
`timescale 1ns/1ps
`default_nettype none
module test_pwm_sleep_restart_control import psrc_pkg::*; #(
    parameter int SC = 20,
    parameter int DIV = 2
);
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic sw_reset = 1'b0;
    logic ext_clk_pin = 1'b0;
    logic ptr_load, reg_wr, reg_rd, bus_stop;
    logic [7:0] ptr_value, reg_wdata, reg_pointer, reg_rdata, m;
    logic respond_sub_one, respond_sub_two, respond_sub_three, respond_broadcast;
    logic oscillator_running, pwm_running, pwm_period_end, channel_restart;
    logic [11:0] pwm_count, cnt0;
    logic [CHANNELS-1:0] channel_active;
    logic [8*PWM_BYTES-1:0] pwm_regs;
    int n_mismatch = 0;
    int total_checks = 0;
    int n_restart = 0;
    int r0;
    int i;

    always #2.5 clk = ~clk;
    // The external clock is slow enough for the three-stage filter to see every edge.
    always #20 ext_clk_pin = ~ext_clk_pin;
    always @(posedge clk) if (channel_restart === 1'b1) n_restart <= n_restart + 1;

    psrc_top #(.STARTUP_CYCLES(SC), .OSC_DIV(DIV)) u_psrc_top (
        .clk(clk), .rst_n(rst_n), .sw_reset(sw_reset), .ptr_load(ptr_load), .ptr_value(ptr_value),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .bus_stop(bus_stop),
        .ext_clk_pin(ext_clk_pin), .reg_pointer(reg_pointer), .reg_rdata(reg_rdata),
        .respond_sub_one(respond_sub_one), .respond_sub_two(respond_sub_two),
        .respond_sub_three(respond_sub_three), .respond_broadcast(respond_broadcast),
        .oscillator_running(oscillator_running), .pwm_running(pwm_running), .pwm_count(pwm_count),
        .pwm_period_end(pwm_period_end), .channel_active(channel_active),
        .channel_restart(channel_restart), .pwm_regs(pwm_regs));

    psrc_host_model #(.STARTUP_CYCLES(SC)) u_psrc_host_model (
        .clk(clk), .ptr_load(ptr_load), .ptr_value(ptr_value), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .bus_stop(bus_stop), .reg_rdata(reg_rdata));

    task automatic close_out();
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // Selector 0 waits for the period end pulse, 1 for the running oscillator.
    task automatic wait_hi(input int which, input int bound);
        for (i = 0; i < bound; i++) begin
            @(negedge clk);
            if ((which == 0) ? (pwm_period_end === 1'b1) : (oscillator_running === 1'b1)) return;
        end
        n_mismatch++;
        $display("Error at %0t: wait ran out", $time);
        close_out();
    endtask

    task automatic set_flag();
        u_psrc_host_model.wake(8'h21);
        u_psrc_host_model.put(MODE_ONE_ADDR, 8'h31, 1'b1);
        wait_hi(0, 9000);
        u_psrc_host_model.get(MODE_ONE_ADDR, m);
        check(m[BIT_RESTART], 1'b1, "restart flag after sleep");
    endtask

    task automatic t_defaults();
        u_psrc_host_model.get(MODE_ONE_ADDR, m);
        check(m, MODE_ONE_RESET, "mode one reset value");
        check({respond_sub_one, respond_sub_two, respond_sub_three}, 3'b000, "subaddress reset");
        check(respond_broadcast, 1'b1, "broadcast reset");
        check(oscillator_running, 1'b0, "oscillator off at reset");
        check(pwm_running, 1'b0, "no activity at reset");
    endtask

    task automatic t_enables();
        u_psrc_host_model.put(MODE_ONE_ADDR, 8'h1E, 1'b1);
        check({respond_sub_one, respond_sub_two, respond_sub_three, respond_broadcast}, 4'hE, "enables set");
        u_psrc_host_model.put(MODE_ONE_ADDR, 8'h11, 1'b1);
        check({respond_sub_one, respond_sub_two, respond_sub_three, respond_broadcast}, 4'h1, "enables back");
    endtask

    task automatic t_autostep();
        u_psrc_host_model.put(MODE_ONE_ADDR, 8'h31, 1'b1);
        u_psrc_host_model.put(8'h06, 8'h12, 1'b1);
        u_psrc_host_model.put(8'h00, 8'h34, 1'b0);
        check(reg_pointer, 8'h08, "pointer after two writes");
        check(pwm_regs[15:0], 16'h1412, "stepped write landing");
        u_psrc_host_model.put(8'h09, 8'h00, 1'b1);
        u_psrc_host_model.put(8'hF3, 8'h00, 1'b1);
        check(channel_active, 16'h0001, "channel zero active");
    endtask

    task automatic t_wake();
        cnt0 = pwm_count;
        u_psrc_host_model.put(MODE_ONE_ADDR, 8'h21, 1'b1);
        repeat (SC - 4) @(negedge clk);
        check(pwm_count, cnt0, "count frozen before oscillator");
        wait_hi(1, 12);
        cnt0 = pwm_count;
        repeat (10) @(negedge clk);
        check(pwm_count == cnt0, 1'b0, "count moves when running");
    endtask

    task automatic t_restart();
        set_flag();
        check(pwm_regs[8*3+:8], 8'h00, "off high kept asleep");
        check(pwm_regs[8*67+:8], 8'h00, "global kept asleep");
        check(pwm_running, 1'b0, "no activity asleep");
        cnt0 = pwm_count;
        repeat (20) @(negedge clk);
        check(pwm_count, cnt0, "count frozen asleep");
        u_psrc_host_model.put(MODE_ONE_ADDR, 8'h31, 1'b1);
        u_psrc_host_model.get(MODE_ONE_ADDR, m);
        check(m[BIT_RESTART], 1'b1, "write zero keeps flag");
        r0 = n_restart;
        u_psrc_host_model.resume_outputs();
        repeat (2) @(negedge clk);
        check(n_restart, r0 + 1, "one restart pulse");
        check(pwm_running, 1'b1, "activity resumed");
        u_psrc_host_model.get(MODE_ONE_ADDR, m);
        check(m[BIT_RESTART], 1'b0, "flag cleared by restart");
    endtask

    task automatic t_stop_clear();
        set_flag();
        u_psrc_host_model.put(8'h06, 8'h00, 1'b1);
        u_psrc_host_model.get(MODE_ONE_ADDR, m);
        check(m[BIT_RESTART], 1'b1, "flag held until stop");
        u_psrc_host_model.stop();
        u_psrc_host_model.get(MODE_ONE_ADDR, m);
        check(m[BIT_RESTART], 1'b0, "flag cleared by stop");
    endtask

    // Channel one is untouched so far, so its written mask starts empty.
    task automatic t_ack_clear();
        set_flag();
        u_psrc_host_model.put(MODE_TWO_ADDR, 8'h0C, 1'b1);
        u_psrc_host_model.put(8'h0A, 8'h00, 1'b1);
        u_psrc_host_model.put(8'h0B, 8'h00, 1'b1);
        u_psrc_host_model.put(8'h0C, 8'h00, 1'b1);
        u_psrc_host_model.stop();
        u_psrc_host_model.get(MODE_ONE_ADDR, m);
        check(m[BIT_RESTART], 1'b1, "three bytes keep flag");
        u_psrc_host_model.put(8'h0D, 8'h10, 1'b1);
        u_psrc_host_model.get(MODE_ONE_ADDR, m);
        check(m[BIT_RESTART], 1'b0, "fourth byte clears flag");
        u_psrc_host_model.put(MODE_TWO_ADDR, 8'h04, 1'b1);
    endtask

    task automatic t_orderly();
        set_flag();
        u_psrc_host_model.wake(8'h21);
        u_psrc_host_model.quiesce();
        check(channel_active, 16'h0000, "global off stops channels");
        u_psrc_host_model.put(MODE_ONE_ADDR, 8'h31, 1'b1);
        repeat (3) @(negedge clk);
        u_psrc_host_model.get(MODE_ONE_ADDR, m);
        check(m[BIT_RESTART], 1'b0, "orderly sleep clears flag");
        check(oscillator_running, 1'b0, "sleep stops oscillator");
        u_psrc_host_model.put(8'hF3, 8'h00, 1'b1);
    endtask

    task automatic t_sw_reset();
        set_flag();
        @(negedge clk);
        sw_reset = 1'b1;
        @(negedge clk);
        sw_reset = 1'b0;
        u_psrc_host_model.get(MODE_ONE_ADDR, m);
        check(m, MODE_ONE_RESET, "software reset mode one");
    endtask

    task automatic t_ext_clock();
        u_psrc_host_model.put(MODE_ONE_ADDR, 8'h71, 1'b1);
        u_psrc_host_model.put(MODE_ONE_ADDR, 8'h61, 1'b1);
        wait_hi(1, 4);
        cnt0 = pwm_count;
        repeat (40) @(negedge clk);
        check(pwm_count == cnt0, 1'b0, "external clock steps count");
    endtask

    initial begin
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        t_defaults();
        t_enables();
        t_autostep();
        t_wake();
        t_restart();
        t_stop_clear();
        t_ack_clear();
        t_orderly();
        t_sw_reset();
        t_ext_clock();
        close_out();
    end

    initial begin
        repeat (100000) @(posedge clk);
        n_mismatch++;
        close_out();
    end
endmodule
`default_nettype wire
